// file: rtl/tps_pkg.sv
`default_nettype none
package tps_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [11:0] TPS_ADDR_CTRL = 12'h000;
    localparam logic [11:0] TPS_ADDR_SEND_PROLONG = 12'h004;
    localparam logic [11:0] TPS_ADDR_FWD_DELAY = 12'h008;
    localparam logic [11:0] TPS_ADDR_MIN_BLOCK = 12'h00c;
    localparam logic [11:0] TPS_ADDR_BLOCK_PROLONG = 12'h010;
    localparam logic [11:0] TPS_ADDR_STATUS = 12'h014;
    localparam logic [11:0] TPS_ADDR_INPUTS = 12'h018;
    // ************************************************************
    // Field layout and reset values
    // ************************************************************
    localparam int TPS_CTRL_SCHEME_LSB = 0;
    localparam int TPS_CTRL_UNDER_OPT_LSB = 4;
    localparam int TPS_TIME_W = 14;
    localparam logic [13:0] TPS_TIME_RESET = 14'h000a;
    localparam logic [13:0] TPS_TIME_MIN = 14'h0001;
    localparam logic [13:0] TPS_TIME_MAX = 14'h2710;
    localparam logic [31:0] TPS_UNMAPPED_DATA = 32'h0000_0000;
    // ************************************************************
    // Time base
    // ************************************************************
    localparam int TPS_CLK_MHZ = 250;
    localparam int TPS_TICK_US = 1000;
    localparam int TPS_TICK_CYCLES = TPS_CLK_MHZ * TPS_TICK_US;
    // ************************************************************
    // Modes
    // ************************************************************
    typedef enum logic [2:0] {
        TPS_OFF = 3'h0,
        TPS_PERM_UNDER = 3'h1,
        TPS_PERM_OVER = 3'h2,
        TPS_DIR_CMP = 3'h3,
        TPS_DIR_BLK = 3'h4,
        TPS_DIRECT_TRIP = 3'h5
    } tps_scheme_e;
    localparam logic TPS_UNDER_PICKUP = 1'b0;
    localparam logic TPS_UNDER_OVERREACH = 1'b1;
endpackage
`default_nettype wire

// file: rtl/tps_sync.sv
`default_nettype none
module tps_sync #(
    parameter int WIDTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;
    // Only the second stage is read outside
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '0;
            sync_out <= '0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule
`default_nettype wire

// file: rtl/tps_timer.sv
`default_nettype none
module tps_timer #(
    parameter int W = 14
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic trig,
    input wire logic [W-1:0] preset,
    output logic running
);
    logic [W-1:0] cnt_r;
    // Reloads while trig is high, then counts down on ms ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
        end else if (trig) begin
            cnt_r <= preset;
        end else if (tick && cnt_r != '0) begin
            cnt_r <= cnt_r - W'(1);
        end
    end
    assign running = trig || (cnt_r != '0);
endmodule
`default_nettype wire

// file: rtl/tps_scheme_logic.sv
`default_nettype none
// Overview of operation
// - Scheme select: five teleprotection schemes
// - Off is default; outputs stay low
// - Underreach scheme trip uses pickup or overreach
// - Underreach scheme send on underreach, prolonged
// - Pickup option: receive and started trips
// - Overreach option: receive and overreach trips
// - Overreach scheme send follows overreach start
// - Overreach and comparison send extended by trip
// - Overreach scheme trip needs receive and overreach
// - Comparison send follows forward start
// - Comparison trip: receive and forward start
// - Blocking send on backward start, prolonged
// - Blocking: forward start delayed before trip
// - Blocking: received block suppresses trip
// - Long received block is stretched
// - Intertrip: send underreach, trip on receive
// - Two far-end receive channels
// - Outputs are trip and send
// - Send prolongation 1 ms steps, 10 ms
// - Block min and prolong 1 ms, 10 ms
// - Forward delay 1 ms steps, 10 ms
module tps_scheme_logic
    import tps_pkg::*;
#(
    parameter int TICK_CYCLES = TPS_TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic block_in,
    input wire logic carrier_fail_in,
    input wire logic receive_1_in,
    input wire logic receive_2_in,
    input wire logic forward_start_in,
    input wire logic backward_start_in,
    input wire logic underreach_start_in,
    input wire logic overreach_start_in,
    input wire logic general_start_in,
    input wire logic general_trip_in,
    output logic tele_trip,
    output logic send_signal
);
    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [9:0] pins_s;
    tps_sync #(.WIDTH(10)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({block_in, carrier_fail_in, receive_1_in, receive_2_in,
                   forward_start_in, backward_start_in, underreach_start_in,
                   overreach_start_in, general_start_in, general_trip_in}),
        .sync_out(pins_s)
    );
    logic blk_s, cfail_s, rx1_s, rx2_s, fw_s, bw_s, ur_s, or_s, gs_s, gt_s;
    assign {blk_s, cfail_s, rx1_s, rx2_s, fw_s, bw_s, ur_s, or_s, gs_s, gt_s} = pins_s;
    logic rx_any;
    assign rx_any = rx1_s | rx2_s;

    // ************************************************************
    // Settings registers
    // ************************************************************
    tps_scheme_e scheme_r;
    logic under_opt_r;
    logic [TPS_TIME_W-1:0] send_prolong_r, fwd_delay_r, min_block_r, block_prolong_r;

    function automatic logic [TPS_TIME_W-1:0] clamp_time(input logic [31:0] d);
        logic [TPS_TIME_W-1:0] v;
        v = d[TPS_TIME_W-1:0];
        if (d[31:TPS_TIME_W] != '0 || v > TPS_TIME_MAX) begin
            clamp_time = TPS_TIME_MAX;
        end else if (v < TPS_TIME_MIN) begin
            clamp_time = TPS_TIME_MIN;
        end else begin
            clamp_time = v;
        end
    endfunction

    function automatic logic legal_scheme(input logic [2:0] s);
        legal_scheme = (s <= 3'(TPS_DIRECT_TRIP));
    endfunction

    logic wr_en;
    // Write lands only at the edge that completes the transfer
    assign wr_en = psel && penable && pwrite && pready;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scheme_r <= TPS_OFF;
            under_opt_r <= TPS_UNDER_OVERREACH;
            send_prolong_r <= TPS_TIME_RESET;
            fwd_delay_r <= TPS_TIME_RESET;
            min_block_r <= TPS_TIME_RESET;
            block_prolong_r <= TPS_TIME_RESET;
        end else if (wr_en) begin
            unique case (paddr)
                TPS_ADDR_CTRL: begin
                    // Illegal scheme codes are ignored so the block never runs a bad mode
                    if (legal_scheme(pwdata[TPS_CTRL_SCHEME_LSB +: 3])) begin
                        scheme_r <= tps_scheme_e'(pwdata[TPS_CTRL_SCHEME_LSB +: 3]);
                    end
                    under_opt_r <= pwdata[TPS_CTRL_UNDER_OPT_LSB];
                end
                TPS_ADDR_SEND_PROLONG: send_prolong_r <= clamp_time(pwdata);
                TPS_ADDR_FWD_DELAY: fwd_delay_r <= clamp_time(pwdata);
                TPS_ADDR_MIN_BLOCK: min_block_r <= clamp_time(pwdata);
                TPS_ADDR_BLOCK_PROLONG: block_prolong_r <= clamp_time(pwdata);
                default: ;
            endcase
        end
    end

    // ************************************************************
    // Millisecond tick
    // ************************************************************
    logic [17:0] tick_cnt_r;
    logic tick_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_r <= '0;
            tick_r <= 1'b0;
        end else if (tick_cnt_r == 18'(TICK_CYCLES - 1)) begin
            tick_cnt_r <= '0;
            tick_r <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 18'h1;
            tick_r <= 1'b0;
        end
    end

    // ************************************************************
    // Timers
    // ************************************************************
    logic ur_prolong, bw_prolong, fw_delayed_run, blk_long_run, blk_stretch;
    logic fw_d_r, blk_qual_r;
    tps_timer #(.W(TPS_TIME_W)) u_ur_prolong (
        .pclk(pclk), .presetn(presetn), .tick(tick_r),
        .trig(ur_s), .preset(send_prolong_r), .running(ur_prolong)
    );
    tps_timer #(.W(TPS_TIME_W)) u_bw_prolong (
        .pclk(pclk), .presetn(presetn), .tick(tick_r),
        .trig(bw_s), .preset(send_prolong_r), .running(bw_prolong)
    );
    // Forward delay: timer reloads while forward start is low and expires after the delay
    tps_timer #(.W(TPS_TIME_W)) u_fw_delay (
        .pclk(pclk), .presetn(presetn), .tick(tick_r),
        .trig(!fw_s), .preset(fwd_delay_r), .running(fw_delayed_run)
    );
    // Minimum block duration measured the same way on the received signal
    tps_timer #(.W(TPS_TIME_W)) u_blk_min (
        .pclk(pclk), .presetn(presetn), .tick(tick_r),
        .trig(!rx_any), .preset(min_block_r), .running(blk_long_run)
    );
    tps_timer #(.W(TPS_TIME_W)) u_blk_stretch (
        .pclk(pclk), .presetn(presetn), .tick(tick_r),
        .trig(blk_qual_r), .preset(block_prolong_r), .running(blk_stretch)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fw_d_r <= 1'b0;
            blk_qual_r <= 1'b0;
        end else begin
            fw_d_r <= fw_s && !fw_delayed_run;
            blk_qual_r <= rx_any && !blk_long_run;
        end
    end

    // ************************************************************
    // Scheme logic
    // ************************************************************
    logic send_nxt, trip_nxt, rx_perm, blk_rx;
    assign rx_perm = rx_any && !cfail_s;
    assign blk_rx = rx_any || blk_stretch;

    always_comb begin
        send_nxt = 1'b0;
        trip_nxt = 1'b0;
        unique case (scheme_r)
            TPS_OFF: ;
            TPS_PERM_UNDER: begin
                send_nxt = ur_prolong;
                if (under_opt_r == TPS_UNDER_PICKUP) begin
                    trip_nxt = rx_perm && gs_s;
                end else begin
                    trip_nxt = rx_perm && or_s;
                end
            end
            TPS_PERM_OVER: begin
                send_nxt = or_s || gt_s;
                trip_nxt = rx_perm && or_s;
            end
            TPS_DIR_CMP: begin
                send_nxt = fw_s || gt_s;
                trip_nxt = rx_perm && fw_s;
            end
            TPS_DIR_BLK: begin
                send_nxt = bw_prolong;
                // Failed channel cannot prove absence of a block
                trip_nxt = fw_d_r && !blk_rx && !cfail_s;
            end
            TPS_DIRECT_TRIP: begin
                send_nxt = ur_s;
                trip_nxt = rx_perm;
            end
        endcase
        if (blk_s) begin
            send_nxt = 1'b0;
            trip_nxt = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            send_signal <= 1'b0;
            tele_trip <= 1'b0;
        end else begin
            send_signal <= send_nxt;
            tele_trip <= trip_nxt;
        end
    end

    // ************************************************************
    // APB read side
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // One wait state: answer in the cycle after the access phase starts
            pready <= psel && penable && !pready;
            pslverr <= 1'b0;
            prdata <= TPS_UNMAPPED_DATA;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    TPS_ADDR_CTRL: prdata <= {27'h0, under_opt_r, 1'b0, 3'(scheme_r)};
                    TPS_ADDR_SEND_PROLONG: prdata <= {18'h0, send_prolong_r};
                    TPS_ADDR_FWD_DELAY: prdata <= {18'h0, fwd_delay_r};
                    TPS_ADDR_MIN_BLOCK: prdata <= {18'h0, min_block_r};
                    TPS_ADDR_BLOCK_PROLONG: prdata <= {18'h0, block_prolong_r};
                    TPS_ADDR_STATUS: prdata <= {27'h0, blk_stretch, fw_d_r, rx_any,
                                                send_signal, tele_trip};
                    TPS_ADDR_INPUTS: prdata <= {22'h0, pins_s};
                    default: prdata <= TPS_UNMAPPED_DATA;
                endcase
            end else if (psel && penable && !pready) begin
                prdata <= prdata;
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    property p_off_quiet;
        @(posedge pclk) disable iff (!presetn)
        scheme_r == TPS_OFF |=> !send_signal && !tele_trip;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("outputs active while off");

    property p_block_quiet;
        @(posedge pclk) disable iff (!presetn)
        blk_s |=> !send_signal && !tele_trip;
    endproperty
    a_block_quiet: assert property (p_block_quiet) else $error("outputs active under block");

    property p_over_send;
        @(posedge pclk) disable iff (!presetn)
        scheme_r == TPS_PERM_OVER && !blk_s && (or_s || gt_s) |=> send_signal;
    endproperty
    a_over_send: assert property (p_over_send) else $error("overreach send missing");

    property p_over_trip;
        @(posedge pclk) disable iff (!presetn)
        scheme_r == TPS_PERM_OVER && !(rx_any && or_s) |=> !tele_trip;
    endproperty
    a_over_trip: assert property (p_over_trip) else $error("overreach trip without cause");

    property p_cfail_perm;
        @(posedge pclk) disable iff (!presetn)
        cfail_s && scheme_r != TPS_OFF |=> !tele_trip;
    endproperty
    a_cfail_perm: assert property (p_cfail_perm) else $error("trip with channel failed");

    property p_inter_trip;
        @(posedge pclk) disable iff (!presetn)
        scheme_r == TPS_DIRECT_TRIP && rx_any && !cfail_s && !blk_s |=> tele_trip;
    endproperty
    a_inter_trip: assert property (p_inter_trip) else $error("intertrip missing");

    property p_blk_suppress;
        @(posedge pclk) disable iff (!presetn)
        scheme_r == TPS_DIR_BLK && rx_any |=> !tele_trip;
    endproperty
    a_blk_suppress: assert property (p_blk_suppress) else $error("trip despite block");

    property p_dir_send;
        @(posedge pclk) disable iff (!presetn)
        scheme_r == TPS_DIR_CMP && !blk_s && fw_s |=> send_signal;
    endproperty
    a_dir_send: assert property (p_dir_send) else $error("forward send missing");
endmodule
`default_nettype wire

// file: tb/tps_far_end.sv
`default_nettype none
// ****
// Far-end relay: its own send reaches us over each channel enabled in chan_en
// ****
module tps_far_end (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic far_send,
    input wire logic [3:0] dly,
    input wire logic [1:0] chan_en,
    output logic rx1,
    output logic rx2
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] pipe_r;
    // Variable channel latency, so prompt and slow answers both occur
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pipe_r <= '0;
        end else begin
            pipe_r <= {pipe_r[14:0], far_send};
        end
    end
    // A lost channel reads as de-energised, never as a stale level
    assign rx1 = pipe_r[dly] & chan_en[0];
    assign rx2 = pipe_r[dly] & chan_en[1];
endmodule
`default_nettype wire

// file: tb/teleprotection_scheme_logic_tb.sv
`default_nettype none
module teleprotection_scheme_logic_tb
    import tps_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // Short tick keeps the run small; st hold times are in ticks
    localparam int TK = 10;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    // Order: far, block, carrier fail, fw, bw, ur, ov, general start, general trip
    logic [8:0] pins = '0;
    logic [3:0] dly = '0;
    logic [1:0] chan_en = 2'h3;
    logic rx1;
    logic rx2;
    logic tele_trip;
    logic send_signal;
    logic smp = 1'b0;
    logic [4:0] cur = 5'h10;
    logic [31:0] rd_q[$];
    logic [1:0] lvl_q[$];
    int mismatches = 0;
    int total_checks = 0;

    always #2 pclk = ~pclk;

    tps_far_end FAR (.pclk(pclk), .presetn(presetn), .far_send(pins[8]), .dly(dly),
        .chan_en(chan_en), .rx1(rx1), .rx2(rx2));

    tps_scheme_logic #(.TICK_CYCLES(TK)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .block_in(pins[7]), .carrier_fail_in(pins[6]),
        .receive_1_in(rx1), .receive_2_in(rx2), .forward_start_in(pins[5]),
        .backward_start_in(pins[4]), .underreach_start_in(pins[3]),
        .overreach_start_in(pins[2]), .general_start_in(pins[1]),
        .general_trip_in(pins[0]), .tele_trip(tele_trip), .send_signal(send_signal));

    // ****
    // Checking
    // ****
    task automatic final_report();
        // Expected results that were never compared count against the run
        mismatches += rd_q.size() + lvl_q.size();
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk_rd(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED t=%0t rd got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk_lvl(input logic [1:0] g, input logic [1:0] e);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED t=%0t out got=%h exp=%h", $time, g, e);
        end
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            chk_rd({31'h0, pslverr}, 32'h0);
        end
        if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0) begin
            chk_rd(prdata, rd_q.pop_front());
        end
        if (smp && lvl_q.size() > 0) begin
            chk_lvl({tele_trip, send_signal}, lvl_q.pop_front());
        end
    end

    // ****
    // Drivers
    // ****
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [31:0] e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) begin
            rd_q.push_back(e);
        end
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            mismatches++;
            final_report();
        end
    endtask

    task automatic expect_out(input logic [1:0] e);
        lvl_q.push_back(e);
        smp <= 1'b1;
        @(posedge pclk);
        smp <= 1'b0;
    endtask

    // Mode, pins, hold in ms, expected {trip, send}
    task automatic st(input logic [4:0] c, input logic [8:0] v, input int n,
        input logic [1:0] e);
        if (c !== cur) begin
            apb(1'b1, TPS_ADDR_CTRL, {27'h0, c}, '0);
            cur = c;
        end
        @(posedge pclk);
        pins <= v;
        dly <= 4'($urandom % 8);
        chan_en <= 2'($urandom % 3 + 1);
        repeat (n * TK) @(posedge pclk);
        expect_out(e);
    endtask

    // ****
    // Sequence
    // ****
    initial begin
        void'($urandom(32'hc8dafa48));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, TPS_ADDR_CTRL, '0, 32'h10);
        for (int i = 1; i < 5; i++) begin
            apb(1'b0, 12'(4 * i), '0, {18'h0, TPS_TIME_RESET});
        end
        apb(1'b0, 12'h020, '0, TPS_UNMAPPED_DATA);
        apb(1'b1, TPS_ADDR_CTRL, 32'h17, '0);
        apb(1'b0, TPS_ADDR_CTRL, '0, 32'h10);
        apb(1'b1, TPS_ADDR_SEND_PROLONG, 32'h0, '0);
        apb(1'b0, TPS_ADDR_SEND_PROLONG, '0, {18'h0, TPS_TIME_MIN});
        apb(1'b1, TPS_ADDR_SEND_PROLONG, 32'h3fff, '0);
        apb(1'b0, TPS_ADDR_SEND_PROLONG, '0, {18'h0, TPS_TIME_MAX});
        apb(1'b1, TPS_ADDR_SEND_PROLONG, 32'h3, '0);
        apb(1'b1, TPS_ADDR_FWD_DELAY, 32'h4, '0);
        apb(1'b1, TPS_ADDR_MIN_BLOCK, 32'h2, '0);
        apb(1'b1, TPS_ADDR_BLOCK_PROLONG, 32'h3, '0);
        st(5'h10, 9'b1_0011_1111, 2, 2'b00);
        st(5'h11, 9'b0_0000_1000, 2, 2'b01);
        st(5'h11, 9'b1_0000_1000, 2, 2'b01);
        st(5'h11, 9'b1_0000_1100, 2, 2'b11);
        st(5'h11, 9'b0_0000_0000, 1, 2'b01);
        st(5'h11, 9'b0_0000_0000, 4, 2'b00);
        st(5'h01, 9'b1_0000_0100, 2, 2'b00);
        st(5'h01, 9'b1_0000_0010, 2, 2'b10);
        st(5'h01, 9'b0_0000_0000, 6, 2'b00);
        st(5'h12, 9'b0_0000_0100, 2, 2'b01);
        st(5'h12, 9'b1_0000_0100, 2, 2'b11);
        st(5'h12, 9'b1_0000_1000, 2, 2'b00);
        st(5'h12, 9'b0_0000_0101, 2, 2'b01);
        st(5'h12, 9'b0_0000_0001, 2, 2'b01);
        st(5'h12, 9'b0_0000_0000, 6, 2'b00);
        st(5'h13, 9'b0_0010_0000, 2, 2'b01);
        st(5'h13, 9'b1_0010_0000, 2, 2'b11);
        st(5'h13, 9'b1_0000_0100, 2, 2'b00);
        st(5'h13, 9'b0_0010_0001, 2, 2'b01);
        st(5'h13, 9'b0_0000_0001, 2, 2'b01);
        st(5'h13, 9'b0_0000_0000, 6, 2'b00);
        st(5'h15, 9'b1_0000_0000, 2, 2'b10);
        st(5'h15, 9'b1_0100_0000, 2, 2'b00);
        st(5'h15, 9'b1_0000_1000, 2, 2'b11);
        st(5'h15, 9'b1_1000_1000, 2, 2'b00);
        st(5'h15, 9'b0_0000_0000, 6, 2'b00);
        st(5'h14, 9'b0_0001_0000, 2, 2'b01);
        st(5'h14, 9'b0_0000_0000, 1, 2'b01);
        st(5'h14, 9'b0_0000_0000, 4, 2'b00);
        st(5'h14, 9'b0_0010_0000, 2, 2'b00);
        st(5'h14, 9'b0_0010_0000, 4, 2'b10);
        st(5'h14, 9'b1_0010_0000, 2, 2'b00);
        st(5'h14, 9'b1_0010_0000, 3, 2'b00);
        st(5'h14, 9'b0_0010_0000, 1, 2'b00);
        st(5'h14, 9'b0_0010_0000, 5, 2'b10);
        apb(1'b0, TPS_ADDR_STATUS, '0, 32'h9);
        apb(1'b0, TPS_ADDR_INPUTS, '0, 32'h20);
        @(posedge pclk);
        final_report();
    end
endmodule
`default_nettype wire
